// *** hdl/irq_bank_pkg.sv ***
// constants, field layouts and carrier types of the peripheral interrupt bank
package irq_bank_pkg;
   localparam int unsigned ADDR_W = 10;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_FLAGS_A = 8'h0C;
   localparam logic [7:0] IDX_FLAGS_B = 8'h0D;
   localparam logic [7:0] IDX_ENABLES_A = 8'h8C;
   localparam logic [7:0] IDX_ENABLES_B = 8'h8D;
   localparam logic [7:0] IDX_EVENT_LOG = 8'h20;
   localparam logic [7:0] IDX_EVENT_MASK = 8'h21;
   // bit positions in flags a / enables a, flags b and the event log, and the event width
   localparam int BIT_PAR_PORT = 7;
   localparam int BIT_CONV_DONE = 6;
   localparam int BIT_RX_FULL = 5;
   localparam int BIT_TX_EMPTY = 4;
   localparam int BIT_SYNC_SERIAL = 3;
   localparam int BIT_CAPCMP_ONE = 2;
   localparam int BIT_TIMER_TWO = 1;
   localparam int BIT_TIMER_ONE = 0;
   localparam int BIT_CAPCMP_TWO = 0;
   localparam int BIT_LOG_CAPCMP_TWO = 8;
   localparam int EVENT_W = 9;
   // field masks and reset values
   localparam logic [7:0] FLAGS_A_SW_MASK = 8'hCF;
   localparam logic [7:0] FLAGS_A_FULL = 8'hFF;
   localparam logic [7:0] FLAGS_A_NO_PORT = 8'h7F;
   localparam logic [7:0] B_IMPL_MASK = 8'h01;
   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [7:0] RESET_ENABLES = 8'h00;
   localparam logic [8:0] RESET_EVENT = 9'h000;
   localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      CC_OFF = 2'h0,
      CC_CAPTURE = 2'h1,
      CC_COMPARE = 2'h3,
      CC_PWM = 2'h2
   } capcmp_mode_t;

   typedef struct packed {
      logic par_port_access;
      logic conv_done;
      logic rx_buffer_full;
      logic tx_buffer_full;
      logic sync_transfer_done;
      logic sync_master_seq_done;
      logic sync_bus_start_stop;
      logic sync_port_idle;
      logic capcmp_one_capture;
      logic capcmp_one_match;
      logic timer_two_match;
      logic timer_one_ovf;
      logic capcmp_two_capture;
      logic capcmp_two_match;
   } periph_events_t;

   typedef struct packed {
      logic global_irq_gate;
      logic peripheral_group_gate;
   } core_gates_t;
endpackage : irq_bank_pkg

// *** hdl/peripheral_irq_enable_flags.sv ***
// peripheral interrupt enable and flag bank behind an avalon-mm slave
`timescale 1ns/1ps
module peripheral_irq_enable_flags #(
   parameter bit HAS_PAR_PORT = 1'h1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [irq_bank_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire irq_bank_pkg::periph_events_t events,
   input wire irq_bank_pkg::capcmp_mode_t capcmp_one_mode,
   input wire irq_bank_pkg::capcmp_mode_t capcmp_two_mode,
   input wire logic multi_master,
   input wire irq_bank_pkg::core_gates_t gates,
   output logic peripheral_irq_request,
   output logic core_irq,
   output logic block_irq
);

   logic [7:0] peripheral_flags_a;
   logic [7:0] peripheral_flags_b;
   logic [7:0] peripheral_enables_a;
   logic [7:0] peripheral_enables_b;
   logic [8:0] event_log;
   logic [8:0] event_mask;

   // bus decode: one wait cycle, answer while waitrequest is low
   wire req = read | write;
   wire accept = req & ~waitrequest;
   wire first = req & waitrequest;
   wire [7:0] idx = address[irq_bank_pkg::ADDR_W-1:2];
   wire hit_flags_a = idx == irq_bank_pkg::IDX_FLAGS_A;
   wire hit_flags_b = idx == irq_bank_pkg::IDX_FLAGS_B;
   wire hit_enables_a = idx == irq_bank_pkg::IDX_ENABLES_A;
   wire hit_enables_b = idx == irq_bank_pkg::IDX_ENABLES_B;
   wire hit_log = idx == irq_bank_pkg::IDX_EVENT_LOG;
   wire hit_mask = idx == irq_bank_pkg::IDX_EVENT_MASK;
   wire wr_accept = write & accept;
   wire wr_lo = wr_accept & byteenable[0];
   wire [8:0] lane_mask = {byteenable[1], {8{byteenable[0]}}};
   wire [8:0] wdata9 = writedata[8:0] & lane_mask;

   wire [7:0] impl_a = HAS_PAR_PORT ? irq_bank_pkg::FLAGS_A_FULL : irq_bank_pkg::FLAGS_A_NO_PORT;

   // set terms, independent of enables and gates
   wire par_set = HAS_PAR_PORT & events.par_port_access;
   wire sync_idle_set = multi_master & events.sync_port_idle & events.sync_bus_start_stop;
   wire sync_set = events.sync_transfer_done | events.sync_master_seq_done | sync_idle_set;
   wire cc1_set = ((capcmp_one_mode == irq_bank_pkg::CC_CAPTURE) & events.capcmp_one_capture)
      | ((capcmp_one_mode == irq_bank_pkg::CC_COMPARE) & events.capcmp_one_match);
   wire cc2_set = ((capcmp_two_mode == irq_bank_pkg::CC_CAPTURE) & events.capcmp_two_capture)
      | ((capcmp_two_mode == irq_bank_pkg::CC_COMPARE) & events.capcmp_two_match);

   logic [7:0] set_a;
   logic [7:0] live_a;
   always_comb begin
      set_a = irq_bank_pkg::RESET_FLAGS;
      set_a[irq_bank_pkg::BIT_PAR_PORT] = par_set;
      set_a[irq_bank_pkg::BIT_CONV_DONE] = events.conv_done;
      set_a[irq_bank_pkg::BIT_SYNC_SERIAL] = sync_set;
      set_a[irq_bank_pkg::BIT_CAPCMP_ONE] = cc1_set;
      set_a[irq_bank_pkg::BIT_TIMER_TWO] = events.timer_two_match;
      set_a[irq_bank_pkg::BIT_TIMER_ONE] = events.timer_one_ovf;
      live_a = irq_bank_pkg::RESET_FLAGS;
      live_a[irq_bank_pkg::BIT_RX_FULL] = events.rx_buffer_full;
      live_a[irq_bank_pkg::BIT_TX_EMPTY] = ~events.tx_buffer_full;
   end

   // software writes value, event set wins over a write of zero
   wire [7:0] sw_a = irq_bank_pkg::FLAGS_A_SW_MASK;
   wire [7:0] kept_a = (wr_lo & hit_flags_a)
      ? ((writedata[7:0] & sw_a) | (peripheral_flags_a & ~sw_a)) : peripheral_flags_a;
   wire [7:0] next_flags_a = (((kept_a | set_a) & sw_a) | live_a) & impl_a;
   wire [7:0] kept_b = (wr_lo & hit_flags_b) ? writedata[7:0] : peripheral_flags_b;
   wire [7:0] next_flags_b = (kept_b | {7'h00, cc2_set}) & irq_bank_pkg::B_IMPL_MASK;
   wire [7:0] next_enables_a = (wr_lo & hit_enables_a)
      ? (writedata[7:0] & impl_a) : peripheral_enables_a;
   wire [7:0] next_enables_b = (wr_lo & hit_enables_b)
      ? (writedata[7:0] & irq_bank_pkg::B_IMPL_MASK) : peripheral_enables_b;

   // event log: sticky record of each flag rising, write one to clear
   wire [8:0] rise = {next_flags_b[irq_bank_pkg::BIT_CAPCMP_TWO], next_flags_a}
      & ~{peripheral_flags_b[irq_bank_pkg::BIT_CAPCMP_TWO], peripheral_flags_a};
   wire [8:0] log_clear = (wr_accept & hit_log) ? wdata9 : irq_bank_pkg::RESET_EVENT;
   wire [8:0] next_log = (event_log & ~log_clear) | rise;
   wire [8:0] next_mask = (wr_accept & hit_mask)
      ? ((writedata[8:0] & lane_mask) | (event_mask & ~lane_mask)) : event_mask;

   wire [7:0] pend_a = peripheral_flags_a & peripheral_enables_a;
   wire [7:0] pend_b = peripheral_flags_b & peripheral_enables_b;
   wire pending = |{pend_a, pend_b};

   wire [31:0] rd_value =
      hit_flags_a ? {24'h000000, peripheral_flags_a} :
      hit_flags_b ? {24'h000000, peripheral_flags_b} :
      hit_enables_a ? {24'h000000, peripheral_enables_a} :
      hit_enables_b ? {24'h000000, peripheral_enables_b} :
      hit_log ? {23'h000000, event_log} :
      hit_mask ? {23'h000000, event_mask} :
      irq_bank_pkg::RESET_RDATA;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'h1;
         readdata <= irq_bank_pkg::RESET_RDATA;
      end else begin
         waitrequest <= ~first;
         if (read & waitrequest) begin
            readdata <= rd_value;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_flags_a <= irq_bank_pkg::RESET_FLAGS;
         peripheral_flags_b <= irq_bank_pkg::RESET_FLAGS;
         peripheral_enables_a <= irq_bank_pkg::RESET_ENABLES;
         peripheral_enables_b <= irq_bank_pkg::RESET_ENABLES;
      end else begin
         peripheral_flags_a <= next_flags_a;
         peripheral_flags_b <= next_flags_b;
         peripheral_enables_a <= next_enables_a;
         peripheral_enables_b <= next_enables_b;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         event_log <= irq_bank_pkg::RESET_EVENT;
         event_mask <= irq_bank_pkg::RESET_EVENT;
         block_irq <= 1'h0;
      end else begin
         event_log <= next_log;
         event_mask <= next_mask;
         block_irq <= |(next_log & next_mask);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_irq_request <= 1'h0;
         core_irq <= 1'h0;
      end else begin
         peripheral_irq_request <= pending;
         core_irq <= pending & gates.peripheral_group_gate & gates.global_irq_gate;
      end
   end

   // checks
   sequence s_first_beat;
      req & waitrequest;
   endsequence

   sequence s_answer;
      req & ~waitrequest;
   endsequence

   property p_bus_answer;
      @(posedge clock) disable iff (!rst_n)
      s_first_beat |=> s_answer;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("no answer one cycle after request");

   property p_group_gate;
      @(posedge clock) disable iff (!rst_n)
      !gates.peripheral_group_gate |=> !core_irq;
   endproperty
   a_group_gate: assert property (p_group_gate) else $error("core irq without group gate");

   property p_timer_one_set;
      @(posedge clock) disable iff (!rst_n)
      events.timer_one_ovf ##0 peripheral_enables_a == 8'h00
         |=> peripheral_flags_a[irq_bank_pkg::BIT_TIMER_ONE];
   endproperty
   a_timer_one_set: assert property (p_timer_one_set) else $error("overflow flag not set");

   property p_enables_write;
      @(posedge clock) disable iff (!rst_n)
      wr_lo & hit_enables_a |=> peripheral_enables_a == ($past(writedata[7:0]) & impl_a);
   endproperty
   a_enables_write: assert property (p_enables_write) else $error("enables a write lost");

   property p_par_port;
      @(posedge clock) disable iff (!rst_n)
      events.par_port_access |=> peripheral_flags_a[irq_bank_pkg::BIT_PAR_PORT] == HAS_PAR_PORT;
   endproperty
   a_par_port: assert property (p_par_port) else $error("port access flag wrong");

   property p_conv_sticky;
      @(posedge clock) disable iff (!rst_n)
      events.conv_done |=> peripheral_flags_a[irq_bank_pkg::BIT_CONV_DONE]
         ##1 (peripheral_flags_a[irq_bank_pkg::BIT_CONV_DONE]
         || $past(wr_lo & hit_flags_a));
   endproperty
   a_conv_sticky: assert property (p_conv_sticky) else $error("conversion flag not sticky");

   property p_rx_mirror;
      @(posedge clock) disable iff (!rst_n)
      ##1 peripheral_flags_a[irq_bank_pkg::BIT_RX_FULL] == $past(events.rx_buffer_full);
   endproperty
   a_rx_mirror: assert property (p_rx_mirror) else $error("receive flag not mirroring");

   property p_tx_mirror;
      @(posedge clock) disable iff (!rst_n)
      ##1 peripheral_flags_a[irq_bank_pkg::BIT_TX_EMPTY] == !$past(events.tx_buffer_full);
   endproperty
   a_tx_mirror: assert property (p_tx_mirror) else $error("transmit flag not mirroring");

   property p_sync_set;
      @(posedge clock) disable iff (!rst_n)
      events.sync_transfer_done | events.sync_master_seq_done
         |=> peripheral_flags_a[irq_bank_pkg::BIT_SYNC_SERIAL];
   endproperty
   a_sync_set: assert property (p_sync_set) else $error("sync flag not set");

   property p_sync_idle;
      @(posedge clock) disable iff (!rst_n)
      multi_master & events.sync_port_idle & events.sync_bus_start_stop
         |=> peripheral_flags_a[irq_bank_pkg::BIT_SYNC_SERIAL];
   endproperty
   a_sync_idle: assert property (p_sync_idle) else $error("idle start/stop missed");

   property p_pwm_quiet;
      @(posedge clock) disable iff (!rst_n)
      capcmp_one_mode == irq_bank_pkg::CC_PWM && !peripheral_flags_a[irq_bank_pkg::BIT_CAPCMP_ONE]
         && !(wr_lo & hit_flags_a) |=> !peripheral_flags_a[irq_bank_pkg::BIT_CAPCMP_ONE];
   endproperty
   a_pwm_quiet: assert property (p_pwm_quiet) else $error("capcmp one set in pwm");

   property p_timer_two;
      @(posedge clock) disable iff (!rst_n)
      events.timer_two_match |=> peripheral_flags_a[irq_bank_pkg::BIT_TIMER_TWO];
   endproperty
   a_timer_two: assert property (p_timer_two) else $error("period match flag not set");

   property p_b_width;
      @(posedge clock) disable iff (!rst_n)
      (read & hit_enables_b) ##0 s_first_beat |=> readdata[31:1] == 31'h00000000;
   endproperty
   a_b_width: assert property (p_b_width) else $error("enables b upper bits not zero");

   property p_cc2;
      @(posedge clock) disable iff (!rst_n)
      cc2_set |=> peripheral_flags_b == 8'h01;
   endproperty
   a_cc2: assert property (p_cc2) else $error("capcmp two flag wrong");

   property p_request;
      @(posedge clock) disable iff (!rst_n)
      pending |=> peripheral_irq_request;
   endproperty
   a_request: assert property (p_request) else $error("pending without request");

   property p_global_gate;
      @(posedge clock) disable iff (!rst_n)
      !gates.global_irq_gate
         |=> !core_irq;
   endproperty
   a_global_gate: assert property (p_global_gate) else $error("irq past global gate");

   property p_core_raise;
      @(posedge clock) disable iff (!rst_n)
      pending && gates.peripheral_group_gate && gates.global_irq_gate
         |=> core_irq;
   endproperty
   a_core_raise: assert property (p_core_raise) else $error("gated irq missing");

   property p_request_drop;
      @(posedge clock) disable iff (!rst_n)
      !pending
         |=> !peripheral_irq_request;
   endproperty
   a_request_drop: assert property (p_request_drop) else $error("stale request");

   property p_core_has_req;
      @(posedge clock) disable iff (!rst_n)
      core_irq
         |-> peripheral_irq_request;
   endproperty
   a_core_has_req: assert property (p_core_has_req) else $error("core irq alone");

   property p_enables_b_write;
      @(posedge clock) disable iff (!rst_n)
      wr_lo && hit_enables_b
         |=> peripheral_enables_b == ($past(writedata[7:0]) & irq_bank_pkg::B_IMPL_MASK);
   endproperty
   a_enables_b_write: assert property (p_enables_b_write) else $error("enables b lost");

   property p_b_upper;
      @(posedge clock) disable iff (!rst_n)
      peripheral_enables_b[7:1] == 7'h00
         && peripheral_flags_b[7:1] == 7'h00;
   endproperty
   a_b_upper: assert property (p_b_upper) else $error("b upper bits set");

   property p_t1_sticky;
      @(posedge clock) disable iff (!rst_n)
      peripheral_flags_a[irq_bank_pkg::BIT_TIMER_ONE] && !(wr_lo && hit_flags_a)
         |=> peripheral_flags_a[irq_bank_pkg::BIT_TIMER_ONE];
   endproperty
   a_t1_sticky: assert property (p_t1_sticky) else $error("overflow flag lost");

   property p_t2_sticky;
      @(posedge clock) disable iff (!rst_n)
      peripheral_flags_a[irq_bank_pkg::BIT_TIMER_TWO] && !(wr_lo && hit_flags_a)
         |=> peripheral_flags_a[irq_bank_pkg::BIT_TIMER_TWO];
   endproperty
   a_t2_sticky: assert property (p_t2_sticky) else $error("match flag lost");

   property p_par_sticky;
      @(posedge clock) disable iff (!rst_n)
      peripheral_flags_a[irq_bank_pkg::BIT_PAR_PORT] && !(wr_lo && hit_flags_a)
         |=> peripheral_flags_a[irq_bank_pkg::BIT_PAR_PORT];
   endproperty
   a_par_sticky: assert property (p_par_sticky) else $error("port flag lost");

   property p_sync_quiet;
      @(posedge clock) disable iff (!rst_n)
      !multi_master && !events.sync_transfer_done && !events.sync_master_seq_done
         && !peripheral_flags_a[irq_bank_pkg::BIT_SYNC_SERIAL] && !(wr_lo && hit_flags_a)
         |=> !peripheral_flags_a[irq_bank_pkg::BIT_SYNC_SERIAL];
   endproperty
   a_sync_quiet: assert property (p_sync_quiet) else $error("sync flag in single");

   property p_cc2_pwm;
      @(posedge clock) disable iff (!rst_n)
      capcmp_two_mode == irq_bank_pkg::CC_PWM && !(wr_lo && hit_flags_b)
         && !peripheral_flags_b[irq_bank_pkg::BIT_CAPCMP_TWO]
         |=> !peripheral_flags_b[irq_bank_pkg::BIT_CAPCMP_TWO];
   endproperty
   a_cc2_pwm: assert property (p_cc2_pwm) else $error("capcmp two set in pwm");

   property p_mirror_ro;
      @(posedge clock) disable iff (!rst_n)
      wr_lo && hit_flags_a
         |=> peripheral_flags_a[irq_bank_pkg::BIT_RX_FULL] == $past(events.rx_buffer_full)
            && peripheral_flags_a[irq_bank_pkg::BIT_TX_EMPTY] == !$past(events.tx_buffer_full);
   endproperty
   a_mirror_ro: assert property (p_mirror_ro) else $error("mirror bit written");

   property p_log_record;
      @(posedge clock) disable iff (!rst_n)
      |rise
         |=> (event_log & $past(rise)) == $past(rise);
   endproperty
   a_log_record: assert property (p_log_record) else $error("rise not logged");

   property p_block_irq;
      @(posedge clock) disable iff (!rst_n)
      |(next_log & next_mask)
         |=> block_irq;
   endproperty
   a_block_irq: assert property (p_block_irq) else $error("block irq missing");

   property p_release;
      @(posedge clock) disable iff (!rst_n)
      s_answer
         |=> waitrequest;
   endproperty
   a_release: assert property (p_release) else $error("wait not restored");

   property p_read_b;
      @(posedge clock) disable iff (!rst_n)
      read && hit_flags_b && waitrequest
         |=> readdata == {24'h000000, $past(peripheral_flags_b)};
   endproperty
   a_read_b: assert property (p_read_b) else $error("flags b read wrong");

   property p_read_a;
      @(posedge clock) disable iff (!rst_n)
      read && hit_enables_a && waitrequest
         |=> readdata == {24'h000000, $past(peripheral_enables_a)};
   endproperty
   a_read_a: assert property (p_read_a) else $error("enables a read wrong");

endmodule : peripheral_irq_enable_flags

// *** verif/periph_model.sv ***
// far-side peripheral model: registered event pulses and buffer levels
`timescale 1ns/1ps
module periph_model (
   input wire logic clock,
   input wire irq_bank_pkg::periph_events_t pulse,
   input wire logic rx_full,
   input wire logic tx_full,
   output irq_bank_pkg::periph_events_t events
);
   irq_bank_pkg::periph_events_t merged;
   always_comb begin
      merged = pulse;
      merged.rx_buffer_full = rx_full;
      merged.tx_buffer_full = tx_full;
   end
   always_ff @(posedge clock) begin
      events <= merged;
   end
endmodule : periph_model

// *** verif/tb.sv ***
// self-checking bench of the peripheral interrupt bank
`timescale 1ns/1ps
module tb;
   localparam logic [9:0] A_FA = {irq_bank_pkg::IDX_FLAGS_A, 2'h0};
   localparam logic [9:0] A_FB = {irq_bank_pkg::IDX_FLAGS_B, 2'h0};
   localparam logic [9:0] A_EA = {irq_bank_pkg::IDX_ENABLES_A, 2'h0};
   localparam logic [9:0] A_EB = {irq_bank_pkg::IDX_ENABLES_B, 2'h0};
   localparam logic [9:0] A_LOG = {irq_bank_pkg::IDX_EVENT_LOG, 2'h0};
   localparam logic [9:0] A_MSK = {irq_bank_pkg::IDX_EVENT_MASK, 2'h0};
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic [9:0] address = 10'h000;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   irq_bank_pkg::periph_events_t pulse = '0;
   irq_bank_pkg::periph_events_t events;
   irq_bank_pkg::capcmp_mode_t mode_one = irq_bank_pkg::CC_CAPTURE;
   irq_bank_pkg::capcmp_mode_t mode_two = irq_bank_pkg::CC_COMPARE;
   logic multi_master = 1'h1;
   irq_bank_pkg::core_gates_t gates = '0;
   logic rx_full = 1'h0;
   logic tx_full = 1'h1;
   logic periph_irq;
   logic core_irq;
   logic block_irq;
   int fail_count = 0;
   int checks = 0;

   always #2.5 clock = ~clock;

   peripheral_irq_enable_flags i_peripheral_irq_enable_flags (.clock(clock), .rst_n(rst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .events(events), .capcmp_one_mode(mode_one), .capcmp_two_mode(mode_two),
      .multi_master(multi_master), .gates(gates), .peripheral_irq_request(periph_irq),
      .core_irq(core_irq), .block_irq(block_irq));
   periph_model i_periph_model (.clock(clock), .pulse(pulse), .rx_full(rx_full),
      .tx_full(tx_full), .events(events));

   task automatic end_sim();
      $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'h0 && n < 50);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      if (n >= 50) begin
         chk(32'h0, 32'h1, "bus timeout");
         end_sim();
      end
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(1'h0, a, 32'h0000_0000, q);
      chk(q, exp, what);
   endtask : rd

   task automatic fire(input irq_bank_pkg::periph_events_t p);
      @(posedge clock);
      pulse <= p;
      @(posedge clock);
      pulse <= '0;
      repeat (3) @(posedge clock);
   endtask : fire

   task automatic t_regs();
      rd(A_FA, 32'h0, "reset flags a");
      rd(A_FB, 32'h0, "reset flags b");
      rd(A_EA, 32'h0, "reset enables a");
      rd(A_EB, 32'h0, "reset enables b");
      rd(10'h100, 32'h0, "unmapped");
      wr(A_EA, 32'h0000_00FF);
      rd(A_EA, 32'h0000_00FF, "enables a");
      wr(A_EB, 32'h0000_00FF);
      rd(A_EB, 32'h0000_0001, "enables b");
      wr(A_EA, 32'h0);
      wr(A_EB, 32'h0);
      byteenable <= 4'hE;
      wr(A_EA, 32'h0000_00FF);
      rd(A_EA, 32'h0, "lane 0 off");
      wr(A_MSK, 32'h0000_01FF);
      rd(A_MSK, 32'h0000_0100, "lane 1 only");
      byteenable <= 4'hF;
      wr(A_MSK, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_flags();
      irq_bank_pkg::periph_events_t ev[9];
      logic [15:0] ex[9];
      ev = '{default: '0};
      ev[0].par_port_access = 1'h1;
      ev[1].conv_done = 1'h1;
      ev[2].sync_transfer_done = 1'h1;
      ev[3].sync_master_seq_done = 1'h1;
      ev[4].sync_bus_start_stop = 1'h1;
      ev[4].sync_port_idle = 1'h1;
      ev[5].capcmp_one_capture = 1'h1;
      ev[6].timer_two_match = 1'h1;
      ev[7].timer_one_ovf = 1'h1;
      ev[8].capcmp_two_match = 1'h1;
      ex = '{16'h0080, 16'h0040, 16'h0008, 16'h0008, 16'h0008, 16'h0004, 16'h0002,
             16'h0001, 16'h0100};
      for (int i = 0; i < 9; i++) begin
         fire(ev[i]);
         rd(A_FA, {24'h0, ex[i][7:0]}, "flags a event");
         rd(A_FB, {24'h0, ex[i][15:8]}, "flags b event");
         wr(A_FA, 32'h0);
         wr(A_FB, 32'h0);
         rd(A_FA, 32'h0, "flags a cleared");
      end
      mode_one <= irq_bank_pkg::CC_PWM;
      mode_two <= irq_bank_pkg::CC_PWM;
      multi_master <= 1'h0;
      fire(ev[4] | ev[5] | ev[8] | 14'h0011);
      rd(A_FA, 32'h0, "pwm and single master");
      rd(A_FB, 32'h0, "pwm unit two");
      mode_one <= irq_bank_pkg::CC_OFF;
      mode_two <= irq_bank_pkg::CC_CAPTURE;
      fire(14'h0022);
      rd(A_FA, 32'h0, "unit one off");
      rd(A_FB, 32'h0000_0001, "unit two capture");
      wr(A_FB, 32'h0);
      mode_one <= irq_bank_pkg::CC_COMPARE;
      fire(14'h0010);
      rd(A_FA, 32'h0000_0004, "compare match");
      wr(A_FA, 32'h0);
      rx_full <= 1'h1;
      tx_full <= 1'h0;
      repeat (3) @(posedge clock);
      rd(A_FA, 32'h0000_0030, "buffer mirrors");
      wr(A_FA, 32'h0);
      rd(A_FA, 32'h0000_0030, "mirrors read-only");
      rx_full <= 1'h0;
      tx_full <= 1'h1;
      repeat (3) @(posedge clock);
      rd(A_FA, 32'h0, "buffer mirrors back");
      $display("test flags done");
   endtask : t_flags

   task automatic t_irq();
      irq_bank_pkg::periph_events_t t1;
      t1 = '0;
      t1.timer_one_ovf = 1'h1;
      wr(A_FA, 32'h0);
      wr(A_EA, 32'h0000_0001);
      fire(t1);
      for (int g = 0; g < 4; g++) begin
         gates <= g[1:0];
         repeat (3) @(posedge clock);
         chk({31'h0, periph_irq}, 32'h1, "request");
         chk({31'h0, core_irq}, {31'h0, g == 3}, "core gate");
      end
      wr(A_FA, 32'h0);
      repeat (3) @(posedge clock);
      chk({31'h0, periph_irq | core_irq}, 32'h0, "request cleared");
      wr(A_LOG, 32'h0000_01FF);
      wr(A_MSK, 32'h0000_0001);
      repeat (2) @(posedge clock);
      chk({31'h0, block_irq}, 32'h0, "block irq idle");
      fire(t1);
      chk({31'h0, block_irq}, 32'h1, "block irq");
      rd(A_LOG, 32'h0000_0001, "event log");
      wr(A_LOG, 32'h0000_0001);
      repeat (2) @(posedge clock);
      chk({31'h0, block_irq}, 32'h0, "block irq cleared");
      wr(A_MSK, 32'h0);
      wr(A_FA, 32'h0);
      fire(t1);
      chk({31'h0, block_irq}, 32'h0, "masked");
      rd(A_LOG, 32'h0000_0001, "masked log");
      wr(A_LOG, 32'h0000_0001);
      wr(A_FA, 32'h0);
      $display("test irq done");
   endtask : t_irq

   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'h1;
      t_regs();
      t_flags();
      t_irq();
      end_sim();
   end
endmodule : tb
